// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import tsc_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  tsc_mode_e mode = TSC_MODE_CORE;
  logic en = 1'b0;
  logic halt = 1'b0;
  logic stop_n = 1'b1;
  logic sleep_n = 1'b1;
  logic [31:0] cr4 = 32'h0;
  logic [1:0] priv = 2'h0;
  logic stamp = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [11:0] addr = STAMP_REG_ADDR;
  logic [63:0] wdata = 64'h0;
  logic [63:0] rd_data;
  logic [63:0] v0;
  logic rd_valid;
  logic rd_fault;
  logic [31:0] id_feature;
  logic [31:0] id_power;
  int mismatches = 0;
  int checked = 0;
  // 8 ns period
  always #4 clock = ~clock;
  // ratio 3 so the constant rate is visibly slower than the clock
  tsc_counter #(.DIV_W(8), .CONST_RATIO(8'h03)) tsc_counter_i (
    .clock(clock), .rst_n(rst_n), .mode(mode), .core_clk_en(en),
    .halt_instruction(halt), .stop_clock_pin_n(stop_n), .deep_sleep_pin_n(sleep_n),
    .control_register_four(cr4), .priv_level(priv), .read_stamp_instruction(stamp),
    .reg_rd(rd), .reg_wr(wr), .reg_addr(addr), .reg_wdata(wdata), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_fault(rd_fault), .id_feature(id_feature), .id_power(id_power)
  );
  task automatic final_report();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic go(input int n);
    repeat (n) @(posedge clock);
  endtask : go
  // answer is registered at the taking edge itself, sampled 1 ns after it
  task automatic rd_op(input logic s, input logic [11:0] a);
    @(posedge clock);
    stamp <= s;
    rd <= ~s;
    addr <= a;
    @(posedge clock);
    stamp <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask : rd_op
  task automatic wr_op(input logic [11:0] a, input logic [63:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_op
  // mode is only changed under reset, since it is meant to stay static
  task automatic do_reset(input tsc_mode_e m);
    @(posedge clock);
    rst_n <= 1'b0;
    mode <= m;
    go(12);
    rst_n <= 1'b1;
  endtask : do_reset
  // exactly n counted core cycles
  task automatic run(input int n);
    @(posedge clock);
    en <= 1'b1;
    go(n);
    en <= 1'b0;
  endtask : run
  // two stamps taken 40 clocks apart
  task automatic span();
    rd_op(1'b1, STAMP_REG_ADDR);
    v0 = rd_data;
    go(38);
    rd_op(1'b1, STAMP_REG_ADDR);
  endtask : span
  initial begin
    do_reset(TSC_MODE_CORE);
    chk(id_feature[ID_STAMP_BIT], 64'h1);
    chk(id_power[ID_INVAR_BIT], 64'h0);
    rd_op(1'b0, STAMP_REG_ADDR);
    chk(rd_data, 64'h0);
    chk(rd_valid, 64'h1);
    @(posedge clock);
    halt <= 1'b1;
    stop_n <= 1'b0;
    run(7);
    rd_op(1'b1, STAMP_REG_ADDR);
    chk(rd_data, 64'h7);
    wr_op(STAMP_REG_ADDR, 64'hdead_beef_1234_5678);
    rd_op(1'b0, STAMP_REG_ADDR);
    chk(rd_data, 64'h1234_5678);
    // write while counting: load wins, the stamp taken two ticks later reads the load plus one
    @(posedge clock);
    en <= 1'b1;
    wr_op(STAMP_REG_ADDR, 64'h0000_0000_0000_00a0);
    rd_op(1'b1, STAMP_REG_ADDR);
    chk(rd_data, 64'ha1);
    rd_op(1'b1, STAMP_REG_ADDR);
    chk(rd_data, 64'ha3);
    @(posedge clock);
    en <= 1'b0;
    rd_op(1'b0, STAMP_REG_ADDR);
    v0 = rd_data;
    @(posedge clock);
    sleep_n <= 1'b0;
    go(4);
    run(5);
    @(posedge clock);
    sleep_n <= 1'b1;
    go(4);
    rd_op(1'b0, STAMP_REG_ADDR);
    chk(rd_data, v0);
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      cr4 <= (i < 2) ? 32'h4 : 32'h0;
      priv <= (i == 1) ? 2'h0 : 2'h3;
      rd_op(1'b1, STAMP_REG_ADDR);
      chk({rd_fault, rd_valid}, (i == 0) ? 64'h2 : 64'h1);
    end
    wr_op(12'h011, 64'h5);
    rd_op(1'b0, 12'h011);
    chk(rd_fault, 64'h1);
    chk(rd_valid, 64'h1);
    chk(rd_data, 64'h0);
    rd_op(1'b0, STAMP_REG_ADDR);
    chk(rd_data, v0);
    do_reset(TSC_MODE_CONST);
    wr_op(STAMP_REG_ADDR, 64'hfedc_ba98_7654_3210);
    span();
    chk(v0[63:32], 64'hfedc_ba98);
    chk(rd_data - v0, 64'd10);
    do_reset(TSC_MODE_INVAR);
    chk(id_power[ID_INVAR_BIT], 64'h1);
    @(posedge clock);
    sleep_n <= 1'b0;
    go(4);
    span();
    chk(rd_data - v0, 64'd10);
    final_report();
  end
endmodule : testbench

// *** tsc_counter.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - 64-bit counter, zero on reset
// - keeps counting when halted or clock-stopped
// - may stop while deep sleep asserted
// - early mode: one per core clock
// - later mode: constant rate from divider
// - instruction reads non-decreasing values; reads between two counter steps return the same value
// - width and rate prevent ten-year wrap
// - restrict flag limits instruction reads to level 0; register reads at 10h are not restricted
// - read samples counter without serializing
// - register read at 10h gives 64 bits
// - early write loads low half, clears high
// - later write loads all 64 bits
// - identify bit 4 reports counter present
// - invariant mode ignores power states
module tsc_counter
  import tsc_pkg::*;
#(
  parameter int unsigned DIV_W = 8,
  parameter logic [DIV_W-1:0] CONST_RATIO = 8'h00
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire tsc_mode_e mode,
  input wire logic core_clk_en,
  input wire logic halt_instruction,
  input wire logic stop_clock_pin_n,
  input wire logic deep_sleep_pin_n,
  input wire logic [31:0] control_register_four,
  input wire logic [1:0] priv_level,
  input wire logic read_stamp_instruction,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [11:0] reg_addr,
  input wire logic [63:0] reg_wdata,
  output logic [63:0] rd_data,
  output logic rd_valid,
  output logic rd_fault,
  output logic [31:0] id_feature,
  output logic [31:0] id_power
);
  logic [1:0] stop_sync_q;
  logic [1:0] sleep_sync_q;
  logic [1:0] stop_sync_d;
  logic [1:0] sleep_sync_d;
  logic const_tick;
  logic advance;
  logic addr_hit;
  logic stamp_allowed;
  logic [63:0] cycle_stamp_counter_q;
  logic [63:0] cycle_stamp_counter_d;
  logic [63:0] rd_data_q;
  logic [63:0] rd_data_d;
  logic rd_valid_q;
  logic rd_valid_d;
  logic rd_fault_q;
  logic rd_fault_d;

  function automatic logic hits_stamp(input logic [11:0] a);
    return a == STAMP_REG_ADDR;
  endfunction : hits_stamp

  tsc_rate_div #(.DIV_W(DIV_W)) u_div (
    .clock(clock),
    .rst_n(rst_n),
    .ratio(CONST_RATIO),
    .tick(const_tick)
  );

  // pin levels come from off-chip, so two stages first
  always_comb begin
    stop_sync_d = {stop_sync_q[0], stop_clock_pin_n};
    sleep_sync_d = {sleep_sync_q[0], deep_sleep_pin_n};
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stop_sync_q <= 2'h3;
      sleep_sync_q <= 2'h3;
    end else begin
      stop_sync_q <= stop_sync_d;
      sleep_sync_q <= sleep_sync_d;
    end
  end

  // halt and stop clock never gate the count; only deep sleep may
  always_comb begin
    unique case (mode)
      TSC_MODE_CORE: advance = core_clk_en & sleep_sync_q[1];
      TSC_MODE_CONST: advance = const_tick & sleep_sync_q[1];
      TSC_MODE_INVAR: advance = const_tick; // power states ignored
      default: advance = 1'b0;
    endcase
  end

  assign addr_hit = hits_stamp(reg_addr);
  assign stamp_allowed = !control_register_four[TSD_BIT] || (priv_level == 2'h0);

  // counter; a write wins over the tick of the same cycle
  always_comb begin
    cycle_stamp_counter_d = cycle_stamp_counter_q;
    if (advance) begin
      cycle_stamp_counter_d = cycle_stamp_counter_q + 64'h1;
    end
    if (reg_wr && addr_hit) begin
      if (mode == TSC_MODE_CORE) begin
        cycle_stamp_counter_d = {32'h0, reg_wdata[31:0]};
      end else begin
        cycle_stamp_counter_d = reg_wdata;
      end
    end
  end

  // reads sample the live value at once, no draining of older work
  always_comb begin
    rd_data_d = 64'h0;
    rd_valid_d = 1'b0;
    rd_fault_d = 1'b0;
    if (read_stamp_instruction) begin
      if (stamp_allowed) begin
        rd_data_d = cycle_stamp_counter_q;
        rd_valid_d = 1'b1;
      end else begin
        rd_fault_d = 1'b1;
      end
    end else if (reg_rd) begin
      rd_valid_d = 1'b1;
      rd_fault_d = !addr_hit;
      rd_data_d = addr_hit ? cycle_stamp_counter_q : 64'h0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cycle_stamp_counter_q <= STAMP_RESET;
      rd_data_q <= 64'h0;
      rd_valid_q <= 1'b0;
      rd_fault_q <= 1'b0;
    end else begin
      cycle_stamp_counter_q <= cycle_stamp_counter_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      rd_fault_q <= rd_fault_d;
    end
  end

  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign rd_fault = rd_fault_q;
  // identify bits: stamp bit fixed, invariant bit set only in invariant mode
  assign id_feature = 32'h1 << ID_STAMP_BIT;
  assign id_power = (mode == TSC_MODE_INVAR) ? (32'h1 << ID_INVAR_BIT) : 32'h0;

  // assertions
  a_reset_zero: assert property (@(posedge clock) $rose(rst_n) |-> cycle_stamp_counter_q == 64'h0)
    else $error("counter not zero after reset");
  a_halt_counts: assert property (@(posedge clock) disable iff (!rst_n)
    (mode == TSC_MODE_CORE && core_clk_en && sleep_sync_q[1] && !reg_wr
      && (halt_instruction || !stop_sync_q[1]))
    |=> cycle_stamp_counter_q == $past(cycle_stamp_counter_q) + 64'h1)
    else $error("counter stalled during stop clock");
  a_sleep_stop: assert property (@(posedge clock) disable iff (!rst_n)
    (mode != TSC_MODE_INVAR && !sleep_sync_q[1] && !reg_wr) |=> $stable(cycle_stamp_counter_q))
    else $error("counter moved in deep sleep");
  a_core_rate: assert property (@(posedge clock) disable iff (!rst_n)
    (mode == TSC_MODE_CORE && !core_clk_en && !reg_wr) |=> $stable(cycle_stamp_counter_q))
    else $error("counter moved without core clock");
  a_invar_rate: assert property (@(posedge clock) disable iff (!rst_n)
    (mode == TSC_MODE_INVAR && const_tick && !reg_wr)
    |=> cycle_stamp_counter_q == $past(cycle_stamp_counter_q) + 64'h1)
    else $error("invariant counter missed tick");
  a_restrict_read: assert property (@(posedge clock) disable iff (!rst_n)
    (read_stamp_instruction && control_register_four[TSD_BIT] && priv_level != 2'h0)
    |=> rd_fault && !rd_valid)
    else $error("restricted read not refused");
  a_read_value: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_rd && !read_stamp_instruction && addr_hit) |=> rd_valid && rd_data == $past(cycle_stamp_counter_q))
    else $error("register read wrong");
  a_low_write: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_wr && addr_hit && mode == TSC_MODE_CORE) |=> cycle_stamp_counter_q == {32'h0, $past(reg_wdata[31:0])})
    else $error("early write wrong");
  a_full_write: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_wr && addr_hit && mode != TSC_MODE_CORE) |=> cycle_stamp_counter_q == $past(reg_wdata))
    else $error("full write wrong");

  // a granted stamp read, then its answer one cycle later
  sequence s_stamp_granted;
    read_stamp_instruction && stamp_allowed;
  endsequence
  sequence s_stamp_answer;
    rd_valid && !rd_fault && rd_data == $past(cycle_stamp_counter_q);
  endsequence
  a_stamp_value: assert property (@(posedge clock) disable iff (!rst_n)
    s_stamp_granted |=> s_stamp_answer)
    else $error("stamp read wrong");
  // without a write the count never steps back, short of the wrap
  a_no_backstep: assert property (@(posedge clock) disable iff (!rst_n)
    (!(reg_wr && addr_hit) && cycle_stamp_counter_q != {64{1'b1}})
    |=> cycle_stamp_counter_q >= $past(cycle_stamp_counter_q))
    else $error("counter went backwards");
  a_unmapped_read: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_rd && !read_stamp_instruction && !addr_hit) |=> rd_valid && rd_fault && rd_data == 64'h0)
    else $error("unmapped read not faulted");
  // no request, no answer: stale pulses would look like a second read
  a_idle_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    (!read_stamp_instruction && !reg_rd) |=> !rd_valid && !rd_fault)
    else $error("answer without request");
  a_write_wins: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_wr && addr_hit && advance && mode != TSC_MODE_CORE)
    |=> cycle_stamp_counter_q == $past(reg_wdata))
    else $error("tick beat the write");
  // deep sleep must not hold back the invariant count
  a_invar_sleep: assert property (@(posedge clock) disable iff (!rst_n)
    (mode == TSC_MODE_INVAR && !sleep_sync_q[1] && const_tick && !reg_wr)
    |=> cycle_stamp_counter_q == $past(cycle_stamp_counter_q) + 64'h1)
    else $error("invariant count stopped in sleep");
endmodule : tsc_counter

// *** tsc_pkg.sv ***
package tsc_pkg;
  localparam int unsigned CNT_W = 64;
  localparam logic [11:0] STAMP_REG_ADDR = 12'h010;
  localparam logic [63:0] STAMP_RESET = 64'h0;
  localparam int unsigned TSD_BIT = 2;
  localparam int unsigned ID_STAMP_BIT = 4;
  localparam int unsigned ID_INVAR_BIT = 8;
  localparam logic [31:0] EXT_LEAF_POWER = 32'h80000007;
  localparam int unsigned CLOCK_MHZ = 125;
  // ten years in seconds, for the wrap check
  localparam longint unsigned WRAP_YEARS_S = 64'd315360000;
  typedef enum logic [1:0] {
    TSC_MODE_CORE,
    TSC_MODE_CONST,
    TSC_MODE_INVAR
  } tsc_mode_e;
endpackage : tsc_pkg

// *** tsc_rate_div.sv ***
`timescale 1ns/1ps
module tsc_rate_div
  import tsc_pkg::*;
#(
  parameter int unsigned DIV_W = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [DIV_W-1:0] ratio,
  output logic tick
);
  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;

  // one-cycle enable every ratio+1 clocks
  always_comb begin
    tick = (cnt_q >= ratio);
    cnt_d = tick ? '0 : cnt_q + 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : tsc_rate_div
